// File: src/ptbw_cfg.svh
// Constants for the burst write path from the 32-bit bus to a 64-bit back-end.
// Assumes the includer compiles this once per unit; the guard protects that.
`ifndef PTBW_CFG_SVH
`define PTBW_CFG_SVH

// ============================================================
// Bus encodings
`define PTBW_CMD_MEM_WRITE   4'h7
`define PTBW_QW_BIT          2
`define PTBW_WIN_LSB         24

// ============================================================
// Bus timing
// The pins reach the logic two cycles late, so after each taken word the
// target ready stays off until the master's next word has crossed over.
`define PTBW_TRDY_GAP        2'h2

// ============================================================
// Buffer sizing
`define PTBW_FIFO_WIDTH      32
`define PTBW_FIFO_DEPTH      8
`define PTBW_FIFO_CW         4
// Pin inputs lag by two sync stages, so the master may push a few more
// words after the ready drops; this much room must stay free.
`define PTBW_ROOM_LIMIT      4'h4

// ============================================================
// Reset values
`define PTBW_RST_STROBE_N    1'b1
`define PTBW_RST_DATA        64'h0

`endif

// File: src/ptbw_pkg.sv
// Types shared by the burst write path and its bench.
// Assumes ptbw_cfg.svh supplies the numeric constants.
package ptbw_pkg;

  // ============================================================
  // Sampled bus pins
  typedef struct packed {
    logic        frame_n;
    logic        irdy_n;
    logic [31:0] ad;
    logic [3:0]  cbe;
  } ptbw_pins_t;

  // ============================================================
  // Transaction state, one-hot
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_HIT   = 6'b000010,
    ST_SEL   = 6'b000100,
    ST_DATA  = 6'b001000,
    ST_TURN  = 6'b010000,
    ST_CLEAN = 6'b100000
  } ptbw_state_t;

endpackage : ptbw_pkg

// File: src/ptbw_fifo.sv
// Small word buffer with an output register in front of the read side.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps

module ptbw_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8,
  localparam int AW   = $clog2(DEPTH)
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_rd_valid,
  input  wire logic             i_rd_ready,
  output logic [WIDTH-1:0]      o_rd_data,
  output logic [AW:0]           o_count
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      mcnt;
  logic [AW-1:0]    next_wptr;
  logic [AW-1:0]    next_rptr;
  logic [AW:0]      next_mcnt;
  logic             next_rd_valid;
  logic [WIDTH-1:0] next_rd_data;
  logic             wr_fire;
  logic             load;

  assign o_wr_ready = (mcnt != (AW+1)'(DEPTH));
  assign o_count    = (AW+1)'(mcnt + {{AW{1'b0}}, o_rd_valid});

  // ============================================================
  // Next state
  always_comb
  begin
    wr_fire       = i_wr_valid & o_wr_ready;
    load          = (mcnt != '0) & (~o_rd_valid | i_rd_ready);
    next_wptr     = wr_fire ? AW'(wptr + 1'b1) : wptr;
    next_rptr     = load ? AW'(rptr + 1'b1) : rptr;
    next_mcnt     = (AW+1)'(mcnt + {{AW{1'b0}}, wr_fire}
                    - {{AW{1'b0}}, load});
    next_rd_valid = load | (o_rd_valid & ~i_rd_ready);
    next_rd_data  = load ? mem[rptr] : o_rd_data;
  end

  // ============================================================
  // Registers
  always_ff @(posedge i_clk)
  begin
    if (wr_fire)
    begin
      mem[wptr] <= i_wr_data;
    end
    if (i_rst)
    begin
      wptr       <= '0;
      rptr       <= '0;
      mcnt       <= '0;
      o_rd_valid <= 1'b0;
      o_rd_data  <= '0;
    end
    else
    begin
      wptr       <= next_wptr;
      rptr       <= next_rptr;
      mcnt       <= next_mcnt;
      o_rd_valid <= next_rd_valid;
      o_rd_data  <= next_rd_data;
    end
  end

endmodule : ptbw_fifo

// File: src/ptbw_top.sv
// Target burst write path: 32-bit bus words packed into 64-bit back-end
// words with separate low-half and high-half transfer strobes.
// Assumes the bus pins come from outside the clock domain and the back-end
// ready and window base come from logic on the same clock.
//
// Overview of operation
// - Quad-aligned: first word raises low-half strobe.
// - Double-aligned: first word goes on upper half.
// - Double-aligned first word: high strobe needs prior ready.
// - Target ready held only if back-end was ready.
// - Quad-aligned second word: low strobe drops, high strobe rises.
// - Double-aligned second word: low strobe, no write.
// - Quad-aligned cleanup: third word reported by low strobe.
// - Turnaround: select and target ready deasserted.
// - Cleanup: high strobe flushes the half-filled word.
// - Idle: window hit cleared, pins released.
// - Window match drives the hit output.
// - First target ready needs prior back-end ready.
`timescale 1ns/1ps
`include "ptbw_cfg.svh"

module ptbw_top (
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire ptbw_pkg::ptbw_pins_t i_pins,
  input  wire logic [31:0]         i_window_base,
  input  wire logic                i_backend_ready_n,
  output logic                     o_trdy_n,
  output logic                     o_trdy_oe_n,
  output logic                     o_devsel_n,
  output logic                     o_devsel_oe_n,
  output logic                     o_window_hit,
  output logic [31:0]              o_local_address,
  output logic [63:0]              o_local_write_data,
  output logic                     o_low_half_xfer_strobe_n,
  output logic                     o_high_half_xfer_strobe_n
);

  // ============================================================
  // Declarations
  ptbw_pkg::ptbw_pins_t  pins_meta;
  ptbw_pkg::ptbw_pins_t  pins;
  logic                  frame_prev;
  logic [1:0]            gap;
  logic [1:0]            next_gap;
  ptbw_pkg::ptbw_state_t state;
  ptbw_pkg::ptbw_state_t next_state;
  logic                  next_trdy_n;
  logic                  next_devsel_n;
  logic                  next_oe_n;
  logic                  next_hit;
  logic [31:0]           next_address;
  logic                  lane;
  logic                  half_full;
  logic                  next_lane;
  logic                  next_half_full;
  logic                  next_low_n;
  logic                  next_high_n;
  logic [63:0]           next_wdata;
  logic                  capture;
  logic                  accept;
  logic                  room;
  logic                  flush;
  logic                  fifo_wr_ready;
  logic                  fifo_rd_valid;
  logic                  fifo_rd_ready;
  logic [31:0]           fifo_rd_data;
  logic [`PTBW_FIFO_CW-1:0] fifo_count;

  default clocking ptbw_cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  function automatic logic window_match(input logic [31:0] addr,
                                        input logic [31:0] base);
    window_match = addr[31:`PTBW_WIN_LSB] == base[31:`PTBW_WIN_LSB];
  endfunction : window_match

  // ============================================================
  // Pin synchronisers; only the second stage is read by logic.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pins_meta    <= '{frame_n: 1'b1, irdy_n: 1'b1, ad: '0, cbe: '0};
      pins         <= '{frame_n: 1'b1, irdy_n: 1'b1, ad: '0, cbe: '0};
      frame_prev   <= 1'b1;
    end
    else
    begin
      pins_meta    <= i_pins;
      pins         <= pins_meta;
      frame_prev   <= pins.frame_n;
    end
  end

  // ============================================================
  // Buffer between the bus and the half-word packer
  ptbw_fifo #(
    .WIDTH (`PTBW_FIFO_WIDTH),
    .DEPTH (`PTBW_FIFO_DEPTH)
  ) u_fifo (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_wr_valid (accept),
    .o_wr_ready (fifo_wr_ready),
    .i_wr_data  (pins.ad),
    .o_rd_valid (fifo_rd_valid),
    .i_rd_ready (fifo_rd_ready),
    .o_rd_data  (fifo_rd_data),
    .o_count    (fifo_count)
  );

  // ============================================================
  // Bus-side transaction sequencer
  always_comb
  begin
    next_state    = state;
    next_trdy_n   = o_trdy_n;
    next_devsel_n = o_devsel_n;
    next_oe_n     = o_trdy_oe_n;
    next_hit      = o_window_hit;
    next_address  = o_local_address;
    room          = (fifo_count <= `PTBW_ROOM_LIMIT) & fifo_wr_ready;
    accept        = state[3] & ~pins.irdy_n & ~o_trdy_n;
    capture       = state[0] & frame_prev & ~pins.frame_n
                    & (pins.cbe == `PTBW_CMD_MEM_WRITE)
                    & window_match(pins.ad, i_window_base);
    next_gap      = accept ? `PTBW_TRDY_GAP : 2'(gap - {1'b0, |gap});
    case (state)
      ptbw_pkg::ST_IDLE:
      begin
        if (capture)
        begin
          next_hit     = 1'b1;
          next_address = pins.ad;
          next_state   = ptbw_pkg::ST_HIT;
        end
      end
      ptbw_pkg::ST_HIT:
      begin
        next_devsel_n = 1'b0;
        next_oe_n     = 1'b0;
        next_state    = ptbw_pkg::ST_SEL;
      end
      ptbw_pkg::ST_SEL:
      begin
        next_trdy_n = i_backend_ready_n | ~room;
        next_state  = ptbw_pkg::ST_DATA;
      end
      ptbw_pkg::ST_DATA:
      begin
        if (accept & pins.frame_n)
        begin
          next_trdy_n   = 1'b1;
          next_devsel_n = 1'b1;
          next_state    = ptbw_pkg::ST_TURN;
        end
        else
        begin
          // Ready is held only while the back-end keeps up.
          next_trdy_n = i_backend_ready_n | ~room | accept | (|gap);
        end
      end
      ptbw_pkg::ST_TURN:
      begin
        next_state = ptbw_pkg::ST_CLEAN;
      end
      ptbw_pkg::ST_CLEAN:
      begin
        if ((fifo_count == '0) & ~half_full & ~fifo_rd_valid)
        begin
          next_hit   = 1'b0;
          next_oe_n  = 1'b1;
          next_state = ptbw_pkg::ST_IDLE;
        end
      end
      default:
      begin
        next_state    = ptbw_pkg::ST_IDLE;
        next_trdy_n   = 1'b1;
        next_devsel_n = 1'b1;
        next_oe_n     = 1'b1;
        next_hit      = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state           <= ptbw_pkg::ST_IDLE;
      o_trdy_n        <= 1'b1;
      o_devsel_n      <= 1'b1;
      o_trdy_oe_n     <= 1'b1;
      o_window_hit    <= 1'b0;
      o_local_address <= '0;
      gap             <= '0;
    end
    else
    begin
      state           <= next_state;
      o_trdy_n        <= next_trdy_n;
      o_devsel_n      <= next_devsel_n;
      o_trdy_oe_n     <= next_oe_n;
      o_window_hit    <= next_hit;
      o_local_address <= next_address;
      gap             <= next_gap;
    end
  end

  assign o_devsel_oe_n = o_trdy_oe_n;

  // ============================================================
  // Half-word packer and transfer strobes
  // The upper half commits a word, so it waits for a ready back-end;
  // the lower half only stages data and never stalls.
  assign fifo_rd_ready = ~lane | ~i_backend_ready_n;
  assign flush = state[5] & ~fifo_rd_valid & half_full & ~i_backend_ready_n;

  always_comb
  begin
    next_low_n     = `PTBW_RST_STROBE_N;
    next_high_n    = `PTBW_RST_STROBE_N;
    next_lane      = lane;
    next_half_full = half_full;
    next_wdata     = o_local_write_data;
    if (capture)
    begin
      next_lane      = pins.ad[`PTBW_QW_BIT];
      next_half_full = 1'b0;
    end
    else if (fifo_rd_valid & fifo_rd_ready)
    begin
      if (~lane)
      begin
        next_wdata[31:0] = fifo_rd_data;
        next_low_n       = 1'b0;
        next_lane        = 1'b1;
        next_half_full   = 1'b1;
      end
      else
      begin
        next_wdata[63:32] = fifo_rd_data;
        next_high_n       = 1'b0;
        next_lane         = 1'b0;
        next_half_full    = 1'b0;
      end
    end
    else if (flush)
    begin
      next_high_n    = 1'b0;
      next_lane      = 1'b0;
      next_half_full = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      lane                      <= 1'b0;
      half_full                 <= 1'b0;
      o_low_half_xfer_strobe_n  <= `PTBW_RST_STROBE_N;
      o_high_half_xfer_strobe_n <= `PTBW_RST_STROBE_N;
      o_local_write_data        <= `PTBW_RST_DATA;
    end
    else
    begin
      lane                      <= next_lane;
      half_full                 <= next_half_full;
      o_low_half_xfer_strobe_n  <= next_low_n;
      o_high_half_xfer_strobe_n <= next_high_n;
      o_local_write_data        <= next_wdata;
    end
  end

  // ============================================================
  // Assertions
  property p_strobes_exclusive;
    !(!o_low_half_xfer_strobe_n && !o_high_half_xfer_strobe_n);
  endproperty
  a_strobes_exclusive: assert property (p_strobes_exclusive)
    else $error("Both half strobes asserted together.");
  property p_trdy_first;
    $fell(o_trdy_n) |-> !$past(i_backend_ready_n);
  endproperty
  a_trdy_first: assert property (p_trdy_first)
    else $error("Target ready asserted without back-end ready.");
  property p_trdy_hold;
    (state == ptbw_pkg::ST_DATA && i_backend_ready_n) |=> o_trdy_n;
  endproperty
  a_trdy_hold: assert property (p_trdy_hold)
    else $error("Target ready held while back-end stalled.");
  property p_high_needs_ready;
    !o_high_half_xfer_strobe_n |-> !$past(i_backend_ready_n);
  endproperty
  a_high_needs_ready: assert property (p_high_needs_ready)
    else $error("High strobe without prior back-end ready.");
  property p_low_stages;
    !o_low_half_xfer_strobe_n |-> (lane && half_full);
  endproperty
  a_low_stages: assert property (p_low_stages)
    else $error("Low strobe did not leave a half-filled word.");
  property p_turn_release;
    (state == ptbw_pkg::ST_TURN) |-> (o_trdy_n && o_devsel_n)
      ##1 (state == ptbw_pkg::ST_CLEAN);
  endproperty
  a_turn_release: assert property (p_turn_release)
    else $error("Select or ready still low in turnaround.");
  property p_idle_clear;
    $rose(state == ptbw_pkg::ST_IDLE) |->
      (!o_window_hit && o_trdy_oe_n && o_devsel_oe_n);
  endproperty
  a_idle_clear: assert property (p_idle_clear)
    else $error("Hit or pin drive left on at idle.");
  property p_hit_select;
    capture |=> o_window_hit ##1 (!o_devsel_n && !o_devsel_oe_n);
  endproperty
  a_hit_select: assert property (p_hit_select)
    else $error("Window hit not followed by select.");
  property p_align_pick;
    capture |=> (lane == $past(pins.ad[`PTBW_QW_BIT]));
  endproperty
  a_align_pick: assert property (p_align_pick)
    else $error("Alignment lane not taken from address bit.");
  property p_no_overflow;
    accept |-> fifo_wr_ready;
  endproperty
  a_no_overflow: assert property (p_no_overflow)
    else $error("Bus word accepted into a full buffer.");

  c_flush: cover property (flush);
  c_dword_start: cover property (capture && pins.ad[`PTBW_QW_BIT]);
  c_stall: cover property (!room && state == ptbw_pkg::ST_DATA);

endmodule : ptbw_top

// File: tb/ptbw_backend_model.sv
// Back-end model that receives the packed words behind the burst write path.
// Assumes the block's clock and reset and a stall request from the bench.
`timescale 1ns/1ps

module ptbw_backend_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_slow,
  input  wire logic        i_low_n,
  input  wire logic        i_high_n,
  input  wire logic [63:0] i_data,
  output logic             o_ready_n,
  output logic             o_commit,
  output logic [63:0]      o_word,
  output logic             o_stage
);
  logic [1:0] phase;

  // ============================================================
  // Ready pacing and word capture
  // A slow back-end is ready one cycle in four, which also paces the target ready.
  always_ff @(posedge i_clk)
  begin
    phase     <= i_rst ? 2'h0 : phase + 2'h1;
    o_ready_n <= i_rst | (i_slow & (phase != 2'h0));
    // Only the high strobe writes a whole word to the back-end.
    o_commit  <= ~i_rst & ~i_high_n;
    o_word    <= i_data;
    // The low strobe only stages half a word; nothing is written.
    o_stage   <= ~i_rst & ~i_low_n;
  end
endmodule : ptbw_backend_model

// File: tb/pci_target_burst_write_64b_local_tb.sv
// Self-checking bench: the bench acts as bus master, a model as back-end.
// Assumes the design files and ptbw_cfg.svh are compiled first.
`timescale 1ns/1ps
`include "ptbw_cfg.svh"

module pci_target_burst_write_64b_local_tb;
  logic                 clk;
  logic                 rst;
  ptbw_pkg::ptbw_pins_t pins;
  logic [31:0]          base;
  logic                 slow;
  logic                 rdy_n;
  logic                 trdy_n;
  logic                 trdy_oe_n;
  logic                 devsel_n;
  logic                 devsel_oe_n;
  logic                 hit;
  logic [31:0]          laddr;
  logic [63:0]          wdata;
  logic                 low_n;
  logic                 high_n;
  logic                 commit;
  logic                 stage;
  logic [63:0]          word;
  logic                 prev_rdy_n;
  logic                 hit_seen;
  logic [63:0]          exp_w[$];
  logic [63:0]          exp_m[$];
  int                   fails;
  int                   compares;
  int                   stages;
  int                   stages_exp;

  ptbw_top dut_u (
    .i_clk                     (clk),
    .i_rst                     (rst),
    .i_pins                    (pins),
    .i_window_base             (base),
    .i_backend_ready_n         (rdy_n),
    .o_trdy_n                  (trdy_n),
    .o_trdy_oe_n               (trdy_oe_n),
    .o_devsel_n                (devsel_n),
    .o_devsel_oe_n             (devsel_oe_n),
    .o_window_hit              (hit),
    .o_local_address           (laddr),
    .o_local_write_data        (wdata),
    .o_low_half_xfer_strobe_n  (low_n),
    .o_high_half_xfer_strobe_n (high_n)
  );

  ptbw_backend_model be_u (
    .i_clk     (clk),
    .i_rst     (rst),
    .i_slow    (slow),
    .i_low_n   (low_n),
    .i_high_n  (high_n),
    .i_data    (wdata),
    .o_ready_n (rdy_n),
    .o_commit  (commit),
    .o_word    (word),
    .o_stage   (stage)
  );

  // ============================================================
  // Reporting
  task automatic check(string what, logic [63:0] e, logic [63:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic report_and_stop();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // ============================================================
  // Back-end side monitor
  always @(posedge clk)
  begin
    prev_rdy_n <= rdy_n;
    if (!rst)
    begin
      if (hit === 1'b1)
        hit_seen <= 1'b1;
      if (trdy_n === 1'b0)
        check("trdy while back-end busy", 1'b0, prev_rdy_n);
      if (high_n === 1'b0)
        check("commit while back-end busy", 1'b0, prev_rdy_n);
      if (low_n === 1'b0)
        check("both strobes", 1'b1, high_n);
      if (stage)
        stages++;
      if (commit)
      begin
        check("commit pending", 1'b1, exp_w.size() != 0);
        if (exp_w.size() != 0)
        begin
          check("word", exp_w[0] & exp_m[0], word & exp_m[0]);
          void'(exp_w.pop_front());
          void'(exp_m.pop_front());
        end
      end
    end
  end

  // ============================================================
  // One burst: expectations first, then the master's cycles
  task automatic run(int t, bit lane, int n, bit s, bit win, bit wr);
    logic [31:0] r;
    logic [31:0] a;
    logic [31:0] w[$];
    logic [63:0] cur;
    logic [63:0] m;
    int          i;
    int          k;
    bit          go;
    r = $urandom();
    a = {base[31:24] ^ {7'h0, ~win}, r[23:3], lane, 2'b00};
    go = win && wr;
    cur = 64'h0;
    m = 64'h0;
    stages = 0;
    stages_exp = 0;
    for (i = 0; i < n; i++)
    begin
      w.push_back($urandom());
      if (!go)
        continue;
      if (((lane + i) % 2) == 0)
      begin
        cur[31:0] = w[i];
        m = 64'h0000_0000_FFFF_FFFF;
        stages_exp++;
      end
      else
      begin
        cur[63:32] = w[i];
        m[63:32] = 32'hFFFF_FFFF;
        exp_w.push_back(cur);
        exp_m.push_back(m);
        m = 64'h0;
      end
    end
    if (m != 64'h0)
    begin
      exp_w.push_back(cur);
      exp_m.push_back(m);
    end
    slow <= s;
    hit_seen = 1'b0;
    @(posedge clk);
    pins <= '{1'b0, 1'b1, a, wr ? `PTBW_CMD_MEM_WRITE : 4'h6};
    for (i = 0; i < n; i++)
    begin
      @(posedge clk);
      // The last word goes out with frame released.
      pins <= '{i == n - 1, 1'b0, w[i], 4'h0};
      k = 0;
      while (go && trdy_n !== 1'b0 && k < 400)
      begin
        @(posedge clk);
        k++;
      end
      if (!go)
        repeat (12) @(posedge clk);
      check("handshake in time", 1'b1, k < 400);
    end
    @(posedge clk);
    // Released lines: pull-ups high, address lines show a changed pattern.
    pins <= '{1'b1, 1'b1, ~w[n - 1], 4'hF};
    k = 0;
    while (hit !== 1'b0 && k < 400)
    begin
      @(posedge clk);
      k++;
    end
    repeat (4) @(posedge clk);
    check("hit seen", go, hit_seen);
    if (go)
      check("local address", a, laddr);
    check("trdy released", 1'b1, trdy_n);
    check("devsel released", 1'b1, devsel_n);
    check("trdy enable off", 1'b1, trdy_oe_n);
    check("devsel enable off", 1'b1, devsel_oe_n);
    check("words left", 0, exp_w.size());
    check("low strobes", stages_exp, stages);
    exp_w.delete();
    exp_m.delete();
    $display("test %0d done", t);
  endtask : run

  // ============================================================
  // Clock, watchdog and test sequence
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    #1600000;
    fails++;
    report_and_stop();
  end

  initial
  begin
    rst = 1'b1;
    pins = '{1'b1, 1'b1, 32'h0, 4'hF};
    base = 32'h0;
    slow = 1'b0;
    prev_rdy_n = 1'b1;
    hit_seen = 1'b0;
    fails = 0;
    compares = 0;
    stages = 0;
    stages_exp = 0;
    void'($urandom(64));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    base <= $urandom();
    repeat (4) @(posedge clk);
    run(0, 1'b0, 3, 1'b0, 1'b1, 1'b1);
    run(1, 1'b1, 3, 1'b0, 1'b1, 1'b1);
    run(2, 1'b0, 1, 1'b0, 1'b1, 1'b1);
    run(3, 1'b1, 1, 1'b0, 1'b1, 1'b1);
    run(4, 1'b0, 2, 1'b1, 1'b1, 1'b1);
    run(5, 1'b1, 12, 1'b1, 1'b1, 1'b1);
    run(6, 1'b0, 4, 1'b0, 1'b1, 1'b0);
    run(7, 1'b1, 4, 1'b0, 1'b0, 1'b1);
    for (int t = 8; t < 20; t++)
      run(t, $urandom() % 2, 1 + $urandom() % 10, $urandom() % 2,
          1'b1, 1'b1);
    report_and_stop();
  end
endmodule : pci_target_burst_write_64b_local_tb
